// File: design/mso_axil_slave.sv
// axi4-lite slave front end, one write and one read outstanding
`timescale 1ns/1ps
module mso_axil_slave (
  input  wire logic        i_clock,   // system clock
  input  wire logic        i_arst_n,  // async reset, active low
  input  wire logic [7:0]  i_awaddr,  // write address
  input  wire logic        i_awvalid, // write address valid
  output logic             o_awready, // write address ready
  input  wire logic [31:0] i_wdata,   // write data
  input  wire logic [3:0]  i_wstrb,   // write strobes
  input  wire logic        i_wvalid,  // write data valid
  output logic             o_wready,  // write data ready
  output logic [1:0]       o_bresp,   // write response
  output logic             o_bvalid,  // write response valid
  input  wire logic        i_bready,  // write response ready
  input  wire logic [7:0]  i_araddr,  // read address
  input  wire logic        i_arvalid, // read address valid
  output logic             o_arready, // read address ready
  output logic [31:0]      o_rdata,   // read data
  output logic [1:0]       o_rresp,   // read response
  output logic             o_rvalid,  // read data valid
  input  wire logic        i_rready,  // read data ready
  output logic             o_wr_en,   // register write pulse
  output logic [7:0]       o_wr_addr, // latched write address
  output logic [31:0]      o_wr_data, // latched write data
  output logic [3:0]       o_wr_strb, // latched strobes
  input  wire logic        i_wr_ok,   // write address mapped
  input  wire logic [31:0] i_rd_data, // read data for i_araddr
  input  wire logic        i_rd_ok    // read address mapped
);
  logic aw_have_r;
  logic w_have_r;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;

  // channels accepted independently, response only after both
  assign o_awready = ~aw_have_r & ~o_bvalid;
  assign o_wready  = ~w_have_r & ~o_bvalid;
  assign aw_hs     = i_awvalid & o_awready;
  assign w_hs      = i_wvalid & o_wready;
  assign o_wr_en   = aw_have_r & w_have_r & ~o_bvalid;
  assign o_arready = ~o_rvalid;
  assign ar_hs     = i_arvalid & o_arready;

  // write path
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      o_wr_addr <= '0;
      o_wr_data <= '0;
      o_wr_strb <= '0;
      o_bvalid  <= 1'b0;
      o_bresp   <= mso_pkg::RESP_OKAY;
    end else begin
      if (aw_hs) o_wr_addr <= i_awaddr;
      if (w_hs) o_wr_data <= i_wdata;
      if (w_hs) o_wr_strb <= i_wstrb;
      aw_have_r <= (aw_have_r | aw_hs) & ~o_wr_en;
      w_have_r  <= (w_have_r | w_hs) & ~o_wr_en;
      if (o_wr_en) begin
        o_bvalid <= 1'b1;
        o_bresp  <= i_wr_ok ? mso_pkg::RESP_OKAY : mso_pkg::RESP_SLVERR;
      end else if (i_bready) o_bvalid <= 1'b0;
    end
  end

  // read path: data captured at address handshake
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rvalid <= 1'b0;
      o_rdata  <= '0;
      o_rresp  <= mso_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      o_rvalid <= 1'b1;
      o_rdata  <= i_rd_ok ? i_rd_data : 32'h0000_0000;
      o_rresp  <= i_rd_ok ? mso_pkg::RESP_OKAY : mso_pkg::RESP_SLVERR;
    end else if (i_rready) o_rvalid <= 1'b0;
  end
endmodule : mso_axil_slave

// File: design/mso_in_cond.sv
// input conditioner: contact polarity and leading-edge pulse per line
`timescale 1ns/1ps
module mso_in_cond #(
  parameter int W = 8
) (
  input  wire logic         i_clock,  // system clock
  input  wire logic         i_arst_n, // async reset, active low
  input  wire logic [W-1:0] i_raw,    // raw input lines
  input  wire logic [W-1:0] i_nc,     // 1 = normally-closed line
  output logic      [W-1:0] o_level,  // active level after polarity
  output logic      [W-1:0] o_rise    // one-cycle pulse on activation
);
  logic [W-1:0] prev_r;

  // normally-closed lines have their meaning inverted
  assign o_level = i_raw ^ i_nc;
  assign o_rise  = o_level & ~prev_r;

  // previous level for edge detection
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) prev_r <= '0;
    else           prev_r <= o_level;
  end
endmodule : mso_in_cond

// File: design/mso_pkg.sv
// shared constants, register map and types of the motion status output block
package mso_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_AREA = 8'h04;
  localparam logic [7:0] ADDR_GPO  = 8'h08;
  localparam logic [7:0] ADDR_CMD  = 8'h0c;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_POL  = 8'h14;
  // control register fields
  localparam int CTRL_DONE_SEL  = 0;
  localparam int CTRL_RDY_GATE  = 1;
  localparam int CTRL_FREE      = 2;
  localparam int CTRL_W         = 3;
  localparam logic [2:0]  CTRL_RST = 3'h0;
  localparam int AREA_W         = 16;
  localparam logic [15:0] AREA_RST = 16'h0000;
  localparam int GPO_W          = 4;
  localparam logic [3:0]  GPO_RST  = 4'h0;
  // system input and command bit positions
  localparam int IN_FCLR    = 0;
  localparam int IN_PAUSE   = 1;
  localparam int IN_RESUME  = 2;
  localparam int IN_PCANCEL = 3;
  localparam int IN_START   = 4;
  localparam int IN_ABORT   = 5;
  localparam int IN_FREE    = 6;
  localparam int IN_ENERGY  = 7;
  localparam int N_SYS_IN   = 8;
  localparam int N_CMD      = 6;
  localparam logic [7:0] POL_RST = 8'h00;
  // bus response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // status word carried to the pins and to the status register
  typedef struct packed {
    logic brake;
    logic origin;
    logic pause;
    logic limit;
    logic ready;
    logic pulsing;
    logic seq;
    logic done;
    logic fault;
  } mso_status_t;
  localparam int STAT_W = 9;
  // origin tracking states
  typedef enum logic [1:0] {
    ORG_NONE = 2'b00,
    ORG_AT   = 2'b01,
    ORG_AWAY = 2'b10
  } mso_org_t;
endpackage : mso_pkg

// File: design/mso_status_out.sv
// motion controller status and general output logic with register access
// Functional notes
// - normally-closed inputs invert active meaning
// - four general outputs set by register write
// - alarm sets fault; one clear pulse resets once cause gone
// - done source chosen by select and area
// - sequence output high while program runs
// - trailing motion step drops sequence output early
// - pulsing output high; new motions rejected
// - pulsing ignores driver moving input
// - ready when not pulsing, sequencing, faulted
// - ready gate also needs driver ready
// - limit output follows limit input
// - pause status set by pause, cleared variously
// - origin found: assert output, zero position
// - origin reasserts when stopping at zero
// - brake free while energized or release requested, else locked
// - brake request ORs three release sources
// - both brake pins carry same state
// - energize input off locks the brake when no release is requested
`timescale 1ns/1ps
module mso_status_out #(
  parameter int AREA_W = mso_pkg::AREA_W,
  parameter int GPO_W  = mso_pkg::GPO_W
) (
  input  wire logic              i_clock,        // 40 mhz system clock
  input  wire logic              i_arst_n,       // async reset, active low
  input  wire logic [7:0]        i_awaddr,       // axi write address
  input  wire logic              i_awvalid,      // axi write address valid
  output logic                   o_awready,      // axi write address ready
  input  wire logic [31:0]       i_wdata,        // axi write data
  input  wire logic [3:0]        i_wstrb,        // axi write strobes
  input  wire logic              i_wvalid,       // axi write data valid
  output logic                   o_wready,       // axi write data ready
  output logic [1:0]             o_bresp,        // axi write response
  output logic                   o_bvalid,       // axi write response valid
  input  wire logic              i_bready,       // axi write response ready
  input  wire logic [7:0]        i_araddr,       // axi read address
  input  wire logic              i_arvalid,      // axi read address valid
  output logic                   o_arready,      // axi read address ready
  output logic [31:0]            o_rdata,        // axi read data
  output logic [1:0]             o_rresp,        // axi read response
  output logic                   o_rvalid,       // axi read valid
  input  wire logic              i_rready,       // axi read ready
  input  wire logic [7:0]        i_sys_in,       // raw system inputs
  input  wire logic              i_alarm,        // alarm event pulse
  input  wire logic              i_alarm_cause,  // alarm cause still present
  input  wire logic              i_pulsing,      // step pulses being emitted
  input  wire logic              i_seq_running,  // sequence program executing
  input  wire logic              i_seq_tail_go,  // final motion step started
  input  wire logic [31:0]       i_pos_err,      // signed position error
  input  wire logic [31:0]       i_pos_cmd,      // position command value
  input  wire logic              i_drv_done,     // driver done signal
  input  wire logic              i_drv_ready,    // driver ready signal
  input  wire logic              i_drv_moving,   // driver moving signal
  input  wire logic              i_sensorless,   // sensorless seek active
  input  wire logic              i_limit_cond,   // driver limit condition
  input  wire logic              i_seek_ok,      // origin seek success pulse
  input  wire logic              i_energize,     // motor current enabled
  input  wire logic              i_free_remote,  // fieldbus release input
  input  wire logic              i_motion_req,   // new motion command pulse
  output logic                   o_motion_ok,    // motion command accepted
  output logic                   o_motion_rej,   // motion command rejected
  output logic                   o_pos_zero,     // zero position command
  output logic                   o_seek_moving,  // driver moving during seek
  output logic [GPO_W-1:0]       o_gpo,          // general outputs
  output mso_pkg::mso_status_t   o_stat,         // status outputs
  output logic                   o_brake_drv     // brake release, driver pins
);
  // register state
  logic [mso_pkg::CTRL_W-1:0]   ctrl_r;
  logic [AREA_W-1:0]            area_r;
  logic [GPO_W-1:0]             gpo_r;
  logic [mso_pkg::N_SYS_IN-1:0] pol_r;
  logic                         fault_r;
  logic                         pause_r;
  mso_pkg::mso_org_t            org_r;
  mso_pkg::mso_org_t            org_nxt;
  mso_pkg::mso_status_t         stat_nxt;
  logic                         pulsing_d_r;
  // bus wires
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_ok;
  logic [31:0] rd_data;
  logic        rd_ok;
  logic [31:0] ctrl_m;
  logic [31:0] area_m;
  logic [31:0] gpo_m;
  logic [31:0] pol_m;
  // conditioned inputs
  logic [mso_pkg::N_SYS_IN-1:0] in_lvl;
  logic [mso_pkg::N_SYS_IN-1:0] in_rise;
  logic [mso_pkg::N_CMD-1:0]    cmd;
  logic [mso_pkg::N_CMD-1:0]    ev;
  logic                         fault_nxt;
  logic                         pause_nxt;
  logic                         pause_clr;
  logic                         in_area;
  logic                         at_zero;
  logic                         stopped;
  logic                         energy_eff;
  logic                         free_req;

  // magnitude of a signed word
  function automatic logic [31:0] mag(input logic [31:0] v);
    mag = v[31] ? 32'(~v + 32'h0000_0001) : v;
  endfunction : mag

  // byte-lane merge for a register write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) merge[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
  endfunction : merge

  mso_axil_slave u_bus (
    .i_clock   (i_clock),
    .i_arst_n  (i_arst_n),
    .i_awaddr  (i_awaddr),
    .i_awvalid (i_awvalid),
    .o_awready (o_awready),
    .i_wdata   (i_wdata),
    .i_wstrb   (i_wstrb),
    .i_wvalid  (i_wvalid),
    .o_wready  (o_wready),
    .o_bresp   (o_bresp),
    .o_bvalid  (o_bvalid),
    .i_bready  (i_bready),
    .i_araddr  (i_araddr),
    .i_arvalid (i_arvalid),
    .o_arready (o_arready),
    .o_rdata   (o_rdata),
    .o_rresp   (o_rresp),
    .o_rvalid  (o_rvalid),
    .i_rready  (i_rready),
    .o_wr_en   (wr_en),
    .o_wr_addr (wr_addr),
    .o_wr_data (wr_data),
    .o_wr_strb (wr_strb),
    .i_wr_ok   (wr_ok),
    .i_rd_data (rd_data),
    .i_rd_ok   (rd_ok)
  );

  mso_in_cond #(.W(mso_pkg::N_SYS_IN)) u_in (
    .i_clock  (i_clock),
    .i_arst_n (i_arst_n),
    .i_raw    (i_sys_in),
    .i_nc     (pol_r),
    .o_level  (in_lvl),
    .o_rise   (in_rise)
  );

  // address decode and read mux
  assign wr_ok = (wr_addr == mso_pkg::ADDR_CTRL) | (wr_addr == mso_pkg::ADDR_AREA) |
                 (wr_addr == mso_pkg::ADDR_GPO) | (wr_addr == mso_pkg::ADDR_CMD) |
                 (wr_addr == mso_pkg::ADDR_POL);
  assign rd_ok = wr_ok_rd(i_araddr);
  assign rd_data =
    (i_araddr == mso_pkg::ADDR_CTRL) ? 32'(ctrl_r) :
    (i_araddr == mso_pkg::ADDR_AREA) ? 32'(area_r) :
    (i_araddr == mso_pkg::ADDR_GPO)  ? 32'(o_gpo) :
    (i_araddr == mso_pkg::ADDR_STAT) ? 32'(o_stat) :
    (i_araddr == mso_pkg::ADDR_POL)  ? 32'(pol_r) : 32'h0000_0000;

  // strobe-merged write value for each register, cut to width where stored
  assign ctrl_m = merge(32'(ctrl_r), wr_data, wr_strb);
  assign area_m = merge(32'(area_r), wr_data, wr_strb);
  assign gpo_m  = merge(32'(gpo_r), wr_data, wr_strb);
  assign pol_m  = merge(32'(pol_r), wr_data, wr_strb);

  // readable addresses; the command register reads as zero
  function automatic logic wr_ok_rd(input logic [7:0] a);
    wr_ok_rd = (a == mso_pkg::ADDR_CTRL) | (a == mso_pkg::ADDR_AREA) |
               (a == mso_pkg::ADDR_GPO) | (a == mso_pkg::ADDR_CMD) |
               (a == mso_pkg::ADDR_STAT) | (a == mso_pkg::ADDR_POL);
  endfunction : wr_ok_rd

  // command writes are write-one pulses, each acting once
  assign cmd = (wr_en && wr_addr == mso_pkg::ADDR_CMD && wr_strb[0]) ?
               wr_data[mso_pkg::N_CMD-1:0] : '0;
  assign ev  = cmd | in_rise[mso_pkg::N_CMD-1:0];

  // fault: alarm sets, a clear pulse resets once the cause is gone; set wins
  assign fault_nxt = i_alarm | (fault_r & ~(ev[mso_pkg::IN_FCLR] & ~i_alarm_cause));

  // pause: set by pause edge, cleared by resume, cancel, start in sequence, abort
  assign pause_clr = ev[mso_pkg::IN_RESUME] | ev[mso_pkg::IN_PCANCEL] |
                     ev[mso_pkg::IN_ABORT] | (ev[mso_pkg::IN_START] & i_seq_running);
  assign pause_nxt = ev[mso_pkg::IN_PAUSE] | (pause_r & ~pause_clr);

  // motion done source selection
  assign in_area = (area_r == '0) | (mag(i_pos_err) <= 32'(area_r));

  // origin tracking: a stop at position zero after origin is known
  assign at_zero = (i_pos_cmd == 32'h0000_0000);
  assign stopped = pulsing_d_r & ~i_pulsing;
  always_comb begin
    case (org_r)
      mso_pkg::ORG_NONE: org_nxt = i_seek_ok ? mso_pkg::ORG_AT : mso_pkg::ORG_NONE;
      mso_pkg::ORG_AT:   org_nxt = i_seek_ok ? mso_pkg::ORG_AT :
                                   (i_pulsing ? mso_pkg::ORG_AWAY : mso_pkg::ORG_AT);
      mso_pkg::ORG_AWAY: org_nxt = (i_seek_ok | (stopped & at_zero)) ?
                                   mso_pkg::ORG_AT : mso_pkg::ORG_AWAY;
      default:           org_nxt = mso_pkg::ORG_NONE;
    endcase
  end

  // brake release: effective energize or any release request
  assign energy_eff = i_energize & in_lvl[mso_pkg::IN_ENERGY];
  assign free_req   = in_lvl[mso_pkg::IN_FREE] | i_free_remote | ctrl_r[mso_pkg::CTRL_FREE];

  // next status word
  always_comb begin
    stat_nxt         = '0;
    stat_nxt.fault   = fault_nxt;
    stat_nxt.done    = ctrl_r[mso_pkg::CTRL_DONE_SEL] ? i_drv_done : (~i_pulsing & in_area);
    stat_nxt.seq     = i_seq_running & ~i_seq_tail_go;
    stat_nxt.pulsing = i_pulsing;
    stat_nxt.ready   = ~i_pulsing & ~i_seq_running & ~fault_nxt &
                       (~ctrl_r[mso_pkg::CTRL_RDY_GATE] | i_drv_ready);
    stat_nxt.limit   = i_limit_cond;
    stat_nxt.pause   = pause_nxt;
    stat_nxt.origin  = (org_nxt == mso_pkg::ORG_AT);
    stat_nxt.brake   = energy_eff | free_req;
  end

  // software registers
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_r <= mso_pkg::CTRL_RST;
      area_r <= mso_pkg::AREA_RST;
      gpo_r  <= mso_pkg::GPO_RST;
      pol_r  <= mso_pkg::POL_RST;
    end else if (wr_en) begin
      if (wr_addr == mso_pkg::ADDR_CTRL) ctrl_r <= ctrl_m[mso_pkg::CTRL_W-1:0];
      if (wr_addr == mso_pkg::ADDR_AREA) area_r <= area_m[AREA_W-1:0];
      if (wr_addr == mso_pkg::ADDR_GPO)  gpo_r  <= gpo_m[GPO_W-1:0];
      if (wr_addr == mso_pkg::ADDR_POL)  pol_r  <= pol_m[mso_pkg::N_SYS_IN-1:0];
    end
  end

  // controller state and registered outputs
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fault_r       <= 1'b0;
      pause_r       <= 1'b0;
      org_r         <= mso_pkg::ORG_NONE;
      pulsing_d_r   <= 1'b0;
      o_stat        <= '0;
      o_brake_drv   <= 1'b0;
      o_gpo         <= '0;
      o_pos_zero    <= 1'b0;
      o_motion_ok   <= 1'b0;
      o_motion_rej  <= 1'b0;
      o_seek_moving <= 1'b0;
    end else begin
      fault_r       <= fault_nxt;
      pause_r       <= pause_nxt;
      org_r         <= org_nxt;
      pulsing_d_r   <= i_pulsing;
      o_stat        <= stat_nxt;
      o_brake_drv   <= stat_nxt.brake;
      o_gpo         <= gpo_r;
      o_pos_zero    <= i_seek_ok;
      o_motion_ok   <= i_motion_req & ~i_pulsing;
      o_motion_rej  <= i_motion_req & i_pulsing;
      o_seek_moving <= i_drv_moving & i_sensorless;
    end
  end

  // checks
  sequence alarm_seen_s;
    i_alarm;
  endsequence
  sequence fault_on_s;
    ##1 o_stat.fault;
  endsequence
  sequence stop_at_zero_s;
    (org_r == mso_pkg::ORG_AWAY) && stopped && at_zero;
  endsequence

  // fault flag
  fault_set_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    alarm_seen_s |-> fault_on_s) else $error("fault not set by alarm");

  fault_hold_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (fault_r && !ev[mso_pkg::IN_FCLR] && !i_alarm) |=> o_stat.fault)
    else $error("fault dropped without clear");

  fault_clear_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (ev[mso_pkg::IN_FCLR] && !i_alarm_cause && !i_alarm) |=> !o_stat.fault)
    else $error("fault not cleared");

  // ready, sequence, motion acceptance and seek moving
  ready_term_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    o_stat.ready |-> !o_stat.pulsing && !o_stat.fault && $past(!i_seq_running))
    else $error("ready while busy");

  ready_gate_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (ctrl_r[mso_pkg::CTRL_RDY_GATE] && !i_drv_ready) |=> !o_stat.ready)
    else $error("ready without driver ready");

  seq_drop_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    i_seq_tail_go |=> !o_stat.seq) else $error("sequence output held");

  motion_rej_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_motion_req && i_pulsing) |=> o_motion_rej && !o_motion_ok)
    else $error("motion accepted while pulsing");

  seek_move_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    o_seek_moving |-> $past(i_sensorless)) else $error("moving used outside seek");

  // limit and pause status
  limit_follow_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    ##1 o_stat.limit == $past(i_limit_cond)) else $error("limit not following");

  pause_clear_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (ev[mso_pkg::IN_ABORT] && !ev[mso_pkg::IN_PAUSE]) |=> !o_stat.pause)
    else $error("pause survived abort");

  // brake release
  brake_same_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    o_brake_drv == o_stat.brake) else $error("brake pins differ");

  brake_lock_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (!energy_eff && !free_req) |=> !o_stat.brake) else $error("brake not locked");

  brake_free_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    free_req |=> o_stat.brake) else $error("brake not released");

  // origin and done
  origin_seek_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    i_seek_ok |=> o_stat.origin && o_pos_zero) else $error("origin not reached");

  origin_stop_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    stop_at_zero_s |=> o_stat.origin) else $error("origin not regained");

  done_sel_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    ctrl_r[mso_pkg::CTRL_DONE_SEL] |=> o_stat.done == $past(i_drv_done))
    else $error("done not from driver");
endmodule : mso_status_out

// File: dv/mso_drv_model.sv
// motor driver model: done, ready, moving and limit lines toward the controller
`timescale 1ns/1ps
module mso_drv_model (
  input  wire logic       i_clock,      // system clock
  input  wire logic       i_arst_n,     // async reset, active low
  input  wire logic [3:0] i_set,        // wanted done, ready, moving, limit
  output logic            o_drv_done,   // driver done line
  output logic            o_drv_ready,  // driver ready line
  output logic            o_drv_moving, // driver moving line
  output logic            o_limit_cond  // driver limit condition line
);
  // a real driver answers a cycle late; all lines low while in reset
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {o_drv_done, o_drv_ready, o_drv_moving, o_limit_cond} <= 4'h0;
    end else begin
      {o_drv_done, o_drv_ready, o_drv_moving, o_limit_cond} <= i_set;
    end
  end
endmodule : mso_drv_model

// File: dv/test_mso_status_out.sv
// self-checking bench of the motion status output block
`timescale 1ns/1ps
module test_mso_status_out;
  logic i_clock = 0, i_arst_n = 0, i_awvalid = 0, i_wvalid = 0, i_bready = 0;
  logic i_arvalid = 0, i_rready = 0, i_alarm = 0, i_alarm_cause = 0, i_pulsing = 0;
  logic i_seq_running = 0, i_seq_tail_go = 0, i_sensorless = 0, i_seek_ok = 0;
  logic i_energize = 0, i_free_remote = 0, i_motion_req = 0;
  logic [7:0]  i_awaddr = 8'h00, i_araddr = 8'h00, i_sys_in = 8'h00;
  logic [31:0] i_wdata = 32'h0, i_pos_err = 32'h0, i_pos_cmd = 32'h5, o_rdata, rd;
  logic [3:0]  i_wstrb = 4'hf, drv_set = 4'h0, o_gpo;
  logic i_drv_done, i_drv_ready, i_drv_moving, i_limit_cond, o_awready, o_wready;
  logic o_bvalid, o_arready, o_rvalid, o_motion_ok, o_motion_rej, o_pos_zero;
  logic o_seek_moving, o_brake_drv;
  logic [1:0] o_bresp, o_rresp, rsp;
  mso_pkg::mso_status_t o_stat;
  int failures = 0, n_tests = 0;
  // rows: pulsing, running, tail, driver lines | done, ready, pulsing, seq, limit
  logic [11:0] rows [4] = '{12'h058, 12'h825, 12'h412, 12'h610};
  mso_status_out mso_status_out_inst (.*);
  mso_drv_model mso_drv_model_inst (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_set(drv_set), .o_drv_done(i_drv_done), .o_drv_ready(i_drv_ready),
    .o_drv_moving(i_drv_moving), .o_limit_cond(i_limit_cond));
  // 40 mhz clock
  always #12.5 i_clock = ~i_clock;
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string m);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : cyc
  // bus write: both channels offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1;
    i_wvalid <= 1;
    i_bready <= 1;
    do begin
      @(posedge i_clock);
      if (i_awvalid && o_awready) i_awvalid <= 0;
      if (i_wvalid && o_wready) i_wvalid <= 0;
    end while (o_bvalid !== 1'b1);
    rsp = o_bresp;
    i_bready <= 0;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    @(posedge i_clock);
    i_araddr <= a;
    i_arvalid <= 1;
    i_rready <= 1;
    do begin
      @(posedge i_clock);
      if (i_arvalid && o_arready) i_arvalid <= 0;
    end while (o_rvalid !== 1'b1);
    rd = o_rdata;
    rsp = o_rresp;
    i_rready <= 0;
  endtask : rdr
  task automatic summarize;
    if (failures == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  // watchdog against a hung handshake
  initial begin
    #200us;
    failures++;
    summarize();
  end
  // main sequence
  initial begin
    cyc(1);
    chk(o_stat, 9'h000, "outputs in reset");
    repeat (2) @(posedge i_clock);
    i_arst_n <= 1;
    for (int i = 0; i < 4; i++) begin
      @(posedge i_clock);
      {i_pulsing, i_seq_running, i_seq_tail_go, drv_set} <= rows[i][11:5];
      cyc(2);
      chk({o_stat.done, o_stat.ready, o_stat.pulsing, o_stat.seq, o_stat.limit},
          rows[i][4:0], "status row");
    end
    @(posedge i_clock);
    {i_pulsing, i_seq_running, i_seq_tail_go, drv_set} <= 7'h00;
    wr(mso_pkg::ADDR_CTRL, 32'h2);
    cyc(2);
    chk(o_stat.ready, 1'b0, "gate without driver ready");
    drv_set <= 4'h8;
    wr(mso_pkg::ADDR_CTRL, 32'h1);
    cyc(2);
    chk({o_stat.done, o_stat.ready}, 2'b11, "driver done select");
    wr(mso_pkg::ADDR_CTRL, 32'h0);
    wr(mso_pkg::ADDR_AREA, 32'h4);
    i_pos_err <= 32'h5;
    cyc(2);
    chk(o_stat.done, 1'b0, "outside end area");
    i_pos_err <= 32'hfffffffc;
    cyc(2);
    chk(o_stat.done, 1'b1, "inside end area");
    // fault set, refused clear, single-shot clear by input and command
    i_alarm_cause <= 1;
    @(posedge i_clock);
    i_alarm <= 1;
    cyc(1);
    chk({o_stat.fault, o_stat.ready}, 2'b10, "fault next cycle");
    i_alarm <= 0;
    i_sys_in[0] <= 1;
    cyc(2);
    chk(o_stat.fault, 1'b1, "clear with cause");
    i_sys_in[0] <= 0;
    i_alarm_cause <= 0;
    cyc(1);
    i_sys_in[0] <= 1;
    cyc(2);
    chk(o_stat.fault, 1'b0, "clear by input");
    i_alarm <= 1;
    cyc(1);
    i_alarm <= 0;
    cyc(2);
    chk(o_stat.fault, 1'b1, "held clear acts once");
    i_sys_in[0] <= 0;
    wr(mso_pkg::ADDR_CMD, 32'h1);
    cyc(2);
    chk(o_stat.fault, 1'b0, "clear by command");
    // pause set by command, cleared by each clearing command
    i_seq_running <= 1;
    for (int k = 2; k < 6; k++) begin
      wr(mso_pkg::ADDR_CMD, 32'h2);
      cyc(2);
      chk(o_stat.pause, 1'b1, "pause set");
      wr(mso_pkg::ADDR_CMD, 32'h1 << k);
      cyc(2);
      chk(o_stat.pause, 1'b0, "pause cleared");
    end
    wr(mso_pkg::ADDR_POL, 32'h2);
    cyc(2);
    chk(o_stat.pause, 1'b1, "closed contact pause");
    i_sys_in[5] <= 1;
    cyc(2);
    chk(o_stat.pause, 1'b0, "abort input clears");
    wr(mso_pkg::ADDR_POL, 32'h0);
    {i_sys_in[5], i_seq_running} <= 2'b00;
    // origin found, lost on motion, regained on stop at zero
    i_seek_ok <= 1;
    cyc(1);
    chk(o_pos_zero, 1'b1, "zero position");
    i_seek_ok <= 0;
    i_pulsing <= 1;
    cyc(2);
    chk(o_stat.origin, 1'b0, "origin lost");
    i_motion_req <= 1;
    cyc(1);
    chk({o_motion_rej, o_motion_ok}, 2'b10, "motion rejected");
    {i_motion_req, i_pulsing} <= 2'b00;
    cyc(2);
    chk(o_stat.origin, 1'b0, "stop away from zero");
    {i_pos_cmd, i_pulsing} <= 33'h1;
    cyc(1);
    i_pulsing <= 0;
    cyc(2);
    chk(o_stat.origin, 1'b1, "stop at zero");
    // brake: energize state and release sources
    {i_energize, i_sys_in[7]} <= 2'b11;
    cyc(2);
    chk({o_stat.brake, o_brake_drv}, 2'b11, "energized");
    i_sys_in[7] <= 0;
    cyc(2);
    chk({o_stat.brake, o_brake_drv}, 2'b00, "energize input off");
    i_sys_in[6] <= 1;
    cyc(2);
    chk(o_stat.brake, 1'b1, "release input");
    {i_sys_in[6], i_free_remote} <= 2'b01;
    cyc(2);
    chk(o_stat.brake, 1'b1, "remote release");
    i_free_remote <= 0;
    wr(mso_pkg::ADDR_CTRL, 32'h4);
    cyc(2);
    chk(o_brake_drv, 1'b1, "release command");
    {i_sensorless, drv_set} <= 5'h12;
    cyc(2);
    chk({o_seek_moving, o_stat.pulsing}, 2'b10, "moving seen in seek");
    // general outputs and bus answers
    wr(mso_pkg::ADDR_GPO, 32'ha);
    chk(rsp, mso_pkg::RESP_OKAY, "mapped write");
    cyc(2);
    chk(o_gpo, 4'ha, "general outputs");
    rdr(mso_pkg::ADDR_GPO);
    chk({rsp, rd}, {mso_pkg::RESP_OKAY, 32'ha}, "general readback");
    rdr(8'h40);
    chk({rsp, rd}, {mso_pkg::RESP_SLVERR, 32'h0}, "unmapped read");
    wr(8'h40, 32'hf);
    chk(rsp, mso_pkg::RESP_SLVERR, "unmapped write");
    summarize();
  end
endmodule : test_mso_status_out
